// >>> src/paoc_top.sv
// Output control of a pipelined converter: saturation, latency, modes and registers.
// Functional notes
// R1 - Each result is a 16-bit two's complement word, fifteen magnitude bits and sign.
// R2 - Inputs below negative full scale give the most negative code, no wrap.
// R3 - Inputs above positive full scale give the most positive code, no wrap.
// R4 - Exactly one new output word per conversion clock cycle.
// R5 - Sample taken on falling edge appears thirteen conversion cycles later.
// R6 - Outputs are meaningless during reset or calibration.
// R7 - Data pins are driven only while the read enable is low.
// R8 - Sleep request low idles the converter and stops conversion.
// R9 - Sign bit low for positive input, high for negative input.
// R10 - Zero differential input converts to all zeros.
// R11 - Host keeps the conversion clock within the allowed sample rates.
// R12 - Host switches any input multiplexer on the rising conversion edge.
// R13 - Host holds reset high at least two conversion cycles after power-up.
// R14 - Host holds calibrate high at least two conversion cycles to start it.
// R15 - Calibration lasts 272800 cycles; data invalid until thirteen cycles after.
// R16 - Valid flag output is low whenever valid data is on the outputs.
// R17 - An abstract signed sample is accepted each falling edge into the pipeline.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "paoc_defs.svh"
module paoc_top #(
  parameter int SAMPLE_W = `PAOC_SAMPLE_W,
  parameter int LATENCY = `PAOC_LATENCY,
  parameter int CAL_CYCLES = `PAOC_CAL_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_clk,
  input wire logic conv_reset,
  input wire logic cal_start,
  input wire logic read_n,
  input wire logic sleep_request_n,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic [15:0] data_o,
  output logic data_oe,
  output logic conv_valid_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Conversion edge and saturation.
  // ****************************************
  localparam logic signed [SAMPLE_W-1:0] POS_FS = SAMPLE_W'(signed'(`PAOC_CODE_POS_FS));
  localparam logic signed [SAMPLE_W-1:0] NEG_FS = -(POS_FS + SAMPLE_W'(1));
  logic conv_q_ff, nxt_conv_q, fall;
  paoc_pkg::paoc_word_t sat_word;

  assign nxt_conv_q = conv_clk;
  assign fall = conv_q_ff && !conv_clk;

  always_comb begin
    if (sample_in > POS_FS) begin
      sat_word = `PAOC_CODE_POS_FS; // R3
    end else if (sample_in < NEG_FS) begin
      sat_word = `PAOC_CODE_NEG_FS; // R2
    end else begin
      sat_word = sample_in[15:0]; // R1 R9 R10
    end
  end

  // ****************************************
  // Register requests.
  // ****************************************
  paoc_pkg::paoc_reg_req_s req;
  paoc_pkg::paoc_reg_rsp_s rsp;
  logic sw_sleep_ff, nxt_sw_sleep, cal_pend_ff, nxt_cal_pend;
  logic [31:0] count_ff, nxt_count;
  paoc_pkg::paoc_word_t data_ff, nxt_data;
  logic out_vld_ff, nxt_out_vld;
  paoc_pkg::paoc_state_e state_ff, nxt_state;

  paoc_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rsp(rsp)
  );

  always_comb begin
    rsp.wok = (req.waddr == `PAOC_OFF_CTRL);
    rsp.rok = 1'b1;
    rsp.rdata = 32'h0000_0000;
    unique case (req.raddr)
      `PAOC_OFF_CTRL: rsp.rdata[`PAOC_CTRL_SLEEP_BIT] = sw_sleep_ff;
      `PAOC_OFF_STATUS: begin
        rsp.rdata[4:0] = state_ff;
        rsp.rdata[`PAOC_STAT_VALID_BIT] = !conv_valid_n;
      end
      `PAOC_OFF_DATA: rsp.rdata[15:0] = data_ff;
      `PAOC_OFF_COUNT: rsp.rdata = count_ff;
      default: rsp.rok = 1'b0;
    endcase
  end

  // ****************************************
  // Mode control.
  // ****************************************
  logic [1:0] cal_hold_ff, nxt_cal_hold;
  logic [19:0] st_cnt_ff, nxt_st_cnt;
  logic sleeping, cal_go;

  assign sleeping = !sleep_request_n || sw_sleep_ff;
  assign cal_go = fall && ((cal_start && cal_hold_ff == 2'(`PAOC_CAL_HOLD - 1)) || cal_pend_ff); // R14

  always_comb begin
    nxt_state = state_ff;
    nxt_st_cnt = st_cnt_ff;
    nxt_sw_sleep = sw_sleep_ff;
    nxt_cal_pend = cal_pend_ff;
    nxt_cal_hold = cal_hold_ff;
    if (fall) begin
      if (!cal_start) begin
        nxt_cal_hold = 2'h0;
      end else if (cal_hold_ff != 2'(`PAOC_CAL_HOLD)) begin
        nxt_cal_hold = cal_hold_ff + 2'h1;
      end
    end
    if (req.wr && rsp.wok && req.wstrb[0]) begin
      nxt_sw_sleep = req.wdata[`PAOC_CTRL_SLEEP_BIT];
    end
    unique case (state_ff)
      paoc_pkg::PAOC_ST_RESET, paoc_pkg::PAOC_ST_SLEEP: begin
        nxt_state = paoc_pkg::PAOC_ST_FLUSH;
        nxt_st_cnt = 20'h0_0000;
      end
      paoc_pkg::PAOC_ST_CAL: begin
        if (fall) begin
          if (st_cnt_ff == 20'(CAL_CYCLES - 1)) begin
            nxt_state = paoc_pkg::PAOC_ST_FLUSH; // R15
            nxt_st_cnt = 20'h0_0000;
          end else begin
            nxt_st_cnt = st_cnt_ff + 20'h0_0001;
          end
        end
      end
      paoc_pkg::PAOC_ST_FLUSH: begin
        if (fall) begin
          if (st_cnt_ff == 20'(LATENCY - 1)) begin
            nxt_state = paoc_pkg::PAOC_ST_RUN; // R15
          end else begin
            nxt_st_cnt = st_cnt_ff + 20'h0_0001;
          end
        end
      end
      paoc_pkg::PAOC_ST_RUN: nxt_state = paoc_pkg::PAOC_ST_RUN;
      default: nxt_state = paoc_pkg::PAOC_ST_RESET;
    endcase
    if (cal_go && state_ff != paoc_pkg::PAOC_ST_CAL) begin
      nxt_state = paoc_pkg::PAOC_ST_CAL;
      nxt_st_cnt = 20'h0_0000;
      nxt_cal_pend = 1'b0;
    end
    if (req.wr && rsp.wok && req.wstrb[0] && req.wdata[`PAOC_CTRL_CAL_BIT]) begin
      nxt_cal_pend = 1'b1;
    end
    if (conv_reset) begin
      nxt_state = paoc_pkg::PAOC_ST_RESET; // R6
      nxt_st_cnt = 20'h0_0000;
    end else if (sleeping) begin
      nxt_state = paoc_pkg::PAOC_ST_SLEEP; // R8
      nxt_st_cnt = 20'h0_0000;
    end
  end

  // ****************************************
  // Latency pipeline and output stage.
  // ****************************************
  logic advance, dl_vld, feed_vld;
  paoc_pkg::paoc_word_t dl_word;

  assign advance = fall && state_ff != paoc_pkg::PAOC_ST_SLEEP; // R4 R17
  assign feed_vld = state_ff == paoc_pkg::PAOC_ST_FLUSH || state_ff == paoc_pkg::PAOC_ST_RUN;

  paoc_delay_line #(
    .W(16),
    .DEPTH(LATENCY)
  ) u_pipe (
    .aclk(aclk),
    .aresetn(aresetn),
    .advance(advance),
    .in_valid(feed_vld),
    .in_word(sat_word),
    .out_valid(dl_vld),
    .out_word(dl_word)
  );

  always_comb begin
    nxt_data = data_ff;
    nxt_out_vld = out_vld_ff && feed_vld;
    nxt_count = count_ff;
    if (advance) begin
      nxt_data = dl_word; // R5
      nxt_out_vld = dl_vld && feed_vld;
      if (dl_vld && feed_vld) begin
        nxt_count = count_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_q_ff <= 1'b0;
      state_ff <= paoc_pkg::PAOC_ST_RESET;
      st_cnt_ff <= 20'h0_0000;
      sw_sleep_ff <= 1'b0;
      cal_pend_ff <= 1'b0;
      cal_hold_ff <= 2'h0;
      data_ff <= 16'h0000;
      out_vld_ff <= 1'b0;
      count_ff <= 32'h0000_0000;
    end else begin
      conv_q_ff <= nxt_conv_q;
      state_ff <= nxt_state;
      st_cnt_ff <= nxt_st_cnt;
      sw_sleep_ff <= nxt_sw_sleep;
      cal_pend_ff <= nxt_cal_pend;
      cal_hold_ff <= nxt_cal_hold;
      data_ff <= nxt_data;
      out_vld_ff <= nxt_out_vld;
      count_ff <= nxt_count;
    end
  end

  assign data_o = data_ff;
  assign data_oe = !read_n; // R7
  assign conv_valid_n = !(out_vld_ff && state_ff == paoc_pkg::PAOC_ST_RUN); // R16

  // ****************************************
  // Checks.
  // ****************************************
  a_sat_high: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    sample_in > POS_FS |-> sat_word == `PAOC_CODE_POS_FS) else $error("Positive overrange not clamped.");
  a_sat_low: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    sample_in < NEG_FS |-> sat_word == `PAOC_CODE_NEG_FS) else $error("Negative overrange not clamped.");
  a_sign_bit: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    sample_in != 0 |-> sat_word[15] == (sample_in < 0)) else $error("Sign bit wrong.");
  a_zero_mid: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    sample_in == 0 |-> sat_word == `PAOC_CODE_MID) else $error("Zero input not mid-scale.");
  a_word_cadence: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    advance && dl_vld && feed_vld |=> count_ff == $past(count_ff) + 32'h0000_0001 && data_ff == $past(dl_word))
    else $error("Word not produced on conversion edge.");
  a_out_enable: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    $rose(read_n) |-> !data_oe) else $error("Data driven while read enable high.");
  a_sleep_idle: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    !sleep_request_n && !conv_reset |=> state_ff == paoc_pkg::PAOC_ST_SLEEP && conv_valid_n)
    else $error("Sleep request not honoured.");
  a_busy_invalid: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    state_ff inside {paoc_pkg::PAOC_ST_RESET, paoc_pkg::PAOC_ST_CAL} |-> conv_valid_n)
    else $error("Valid flagged during reset or calibration.");
  a_cal_length: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    state_ff == paoc_pkg::PAOC_ST_CAL |-> st_cnt_ff < 20'(CAL_CYCLES)) else $error("Calibration overran.");
  a_flush_exit: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    state_ff == paoc_pkg::PAOC_ST_FLUSH && fall && st_cnt_ff == 20'(LATENCY - 1) && !conv_reset && !sleeping
    && !cal_go |=> state_ff == paoc_pkg::PAOC_ST_RUN) else $error("Blanking did not end after latency.");
  a_valid_low: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    !conv_valid_n |-> state_ff == paoc_pkg::PAOC_ST_RUN && out_vld_ff) else $error("Valid flag without data.");
  a_stale_drop: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    !feed_vld |=> !dl_vld) else $error("Stale word kept valid.");
  a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    state_ff == paoc_pkg::PAOC_ST_SLEEP |=> $stable(data_ff)) else $error("Data moved while asleep.");
  a_cal_entry: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    cal_go && state_ff != paoc_pkg::PAOC_ST_CAL && !conv_reset && !sleeping
    |=> state_ff == paoc_pkg::PAOC_ST_CAL) else $error("Calibration did not start.");
endmodule
`default_nettype wire

// >>> src/paoc_defs.svh
// Constants for the pipelined converter output control block.
`ifndef PAOC_DEFS_SVH
`define PAOC_DEFS_SVH
`define PAOC_WORD_W 16
`define PAOC_SAMPLE_W 18
`define PAOC_LATENCY 13
`define PAOC_CAL_CYCLES 272800
`define PAOC_CAL_HOLD 2
`define PAOC_CLK_PERIOD_NS 10
`define PAOC_CODE_POS_FS 16'h7FFF
`define PAOC_CODE_NEG_FS 16'h8000
`define PAOC_CODE_MID 16'h0000
`define PAOC_OFF_CTRL 32'h0000_0000
`define PAOC_OFF_STATUS 32'h0000_0004
`define PAOC_OFF_DATA 32'h0000_0008
`define PAOC_OFF_COUNT 32'h0000_000C
`define PAOC_CTRL_SLEEP_BIT 0
`define PAOC_CTRL_CAL_BIT 1
`define PAOC_STAT_VALID_BIT 8
`define PAOC_CTRL_RESET 32'h0000_0000
`define PAOC_RESP_OKAY 2'h0
`define PAOC_RESP_DECERR 2'h3
`endif

// >>> src/paoc_pkg.sv
// Types shared by the converter output control design.
package paoc_pkg;
  typedef enum logic [4:0] {
    PAOC_ST_RESET = 5'b00001,
    PAOC_ST_CAL = 5'b00010,
    PAOC_ST_FLUSH = 5'b00100,
    PAOC_ST_RUN = 5'b01000,
    PAOC_ST_SLEEP = 5'b10000
  } paoc_state_e;
  typedef logic [15:0] paoc_word_t;
  typedef struct packed {
    logic wr;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rd;
    logic [31:0] raddr;
  } paoc_reg_req_s;
  typedef struct packed {
    logic wok;
    logic rok;
    logic [31:0] rdata;
  } paoc_reg_rsp_s;
endpackage

// >>> src/paoc_delay_line.sv
// Shift register of words with valid flags, advanced once per conversion edge.
`timescale 1ns/1ns
`default_nettype none
module paoc_delay_line #(
  parameter int W = 16,
  parameter int DEPTH = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic advance,
  input wire logic in_valid,
  input wire logic [W-1:0] in_word,
  output logic out_valid,
  output logic [W-1:0] out_word
);
  logic [W-1:0] word_ff [DEPTH];
  logic [W-1:0] nxt_word [DEPTH];
  logic [DEPTH-1:0] vld_ff;
  logic [DEPTH-1:0] nxt_vld;

  always_comb begin
    // A dropped feed clears every flag, so words held over a pause never come back as valid.
    nxt_vld = in_valid ? vld_ff : '0;
    for (int i = 0; i < DEPTH; i++) begin
      nxt_word[i] = word_ff[i];
    end
    if (advance) begin
      nxt_word[0] = in_word;
      nxt_vld[0] = in_valid;
      for (int i = 1; i < DEPTH; i++) begin
        nxt_word[i] = word_ff[i-1];
        nxt_vld[i] = vld_ff[i-1] & in_valid;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vld_ff <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        word_ff[i] <= '0;
      end
    end else begin
      vld_ff <= nxt_vld;
      for (int i = 0; i < DEPTH; i++) begin
        word_ff[i] <= nxt_word[i];
      end
    end
  end

  assign out_valid = vld_ff[DEPTH-1];
  assign out_word = word_ff[DEPTH-1];
endmodule
`default_nettype wire

// >>> src/paoc_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register requests.
`timescale 1ns/1ns
`default_nettype none
`include "paoc_defs.svh"
module paoc_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output paoc_pkg::paoc_reg_req_s req,
  input wire paoc_pkg::paoc_reg_rsp_s rsp
);
  logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
  logic [31:0] aw_addr_ff, nxt_aw_addr, w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  assign s_axi_awready = !aw_full_ff;
  assign s_axi_wready = !w_full_ff;
  assign s_axi_arready = !rvalid_ff;

  always_comb begin
    nxt_aw_full = aw_full_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_full = w_full_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    req = '0;
    req.waddr = aw_addr_ff;
    req.wdata = w_data_ff;
    req.wstrb = w_strb_ff;
    req.raddr = s_axi_araddr;
    if (s_axi_awvalid && !aw_full_ff) begin
      nxt_aw_full = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_ff) begin
      nxt_w_full = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_full_ff && w_full_ff && !bvalid_ff) begin
      req.wr = 1'b1;
      nxt_aw_full = 1'b0;
      nxt_w_full = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = rsp.wok ? `PAOC_RESP_OKAY : `PAOC_RESP_DECERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_ff) begin
      req.rd = 1'b1;
      nxt_rvalid = 1'b1;
      nxt_rdata = rsp.rdata;
      nxt_rresp = rsp.rok ? `PAOC_RESP_OKAY : `PAOC_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 32'h0000_0000;
      w_full_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      aw_full_ff <= nxt_aw_full;
      aw_addr_ff <= nxt_aw_addr;
      w_full_ff <= nxt_w_full;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> tb/paoc_host_model.sv
// Host acquisition controller model: conversion clock, samples and word capture.
`timescale 1ns/1ns
`default_nettype none
module paoc_host_model (
  input wire logic aclk,
  input wire logic signed [17:0] next_sample,
  input wire logic [15:0] data_o,
  input wire logic data_oe,
  input wire logic conv_valid_n,
  output logic conv_clk,
  output logic signed [17:0] sample_in,
  output logic [31:0] edge_no,
  output logic cap_stb,
  output logic cap_ok,
  output logic [15:0] cap_word
);
  // ********************************
  // Clock, sample and capture.
  // ********************************
  logic [1:0] ph_ff;
  logic prev_ff;
  initial begin
    ph_ff = 2'h0;
    prev_ff = 1'h0;
    conv_clk = 1'h1;
    sample_in = 18'h0_0000;
    edge_no = 32'h0000_0000;
    cap_stb = 1'h0;
    cap_ok = 1'h0;
    cap_word = 16'h0000;
  end
  always @(posedge aclk) begin
    ph_ff <= ph_ff + 2'h1;
    conv_clk <= (ph_ff == 2'h3) || (ph_ff == 2'h0);
    prev_ff <= conv_clk;
    if (prev_ff && !conv_clk) begin
      edge_no <= edge_no + 32'h0000_0001;
    end
    cap_stb <= (ph_ff == 2'h3);
    if (ph_ff == 2'h3) begin
      sample_in <= next_sample;
      cap_word <= data_oe ? data_o : ~cap_word;
      cap_ok <= !conv_valid_n;
    end
  end
endmodule
`default_nettype wire

// >>> tb/pipelined_adc_output_control_tb.sv
// Self-checking testbench of the converter output control block.
`timescale 1ns/1ns
`default_nettype none
`include "paoc_defs.svh"
module pipelined_adc_output_control_tb;
  localparam int CAL = 20;
  localparam int NR = 11;
  localparam int LIM = 3000;
  typedef struct packed {
    logic [17:0] s;
    logic [15:0] w;
  } paoc_row_s;
  localparam paoc_row_s ROWS [NR] = '{
    '{18'h0_0000, 16'h0000},
    '{18'h0_0001, 16'h0001},
    '{18'h3_ffff, 16'hffff},
    '{18'h0_7fff, 16'h7fff},
    '{18'h0_8000, 16'h7fff},
    '{18'h3_8000, 16'h8000},
    '{18'h3_7fff, 16'h8000},
    '{18'h1_ffff, 16'h7fff},
    '{18'h2_0000, 16'h8000},
    '{18'h0_1234, 16'h1234},
    '{18'h3_edcc, 16'hedcc}
  };
  logic aclk;
  logic aresetn = 1'h0;
  logic conv_reset = 1'h0;
  logic cal_start = 1'h0;
  logic read_n = 1'h0;
  logic sleep_request_n = 1'h1;
  logic conv_clk;
  logic signed [17:0] sample_in;
  logic signed [17:0] nxt;
  logic [15:0] data_o;
  logic data_oe;
  logic conv_valid_n;
  logic [31:0] s_axi_awaddr = 32'h0000_0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready;
  logic s_axi_wready;
  logic s_axi_bvalid;
  logic s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [31:0] edge_no;
  logic cap_stb;
  logic cap_ok;
  logic [15:0] cap_word;
  logic [15:0] hold;
  int num_errors = 0;
  int checks_done = 0;
  assign nxt = ROWS[edge_no % NR].s;
  paoc_top #(.CAL_CYCLES(CAL)) paoc_top_i (.*);
  paoc_host_model paoc_host_model_i (
    .aclk(aclk),
    .next_sample(nxt),
    .data_o(data_o),
    .data_oe(data_oe),
    .conv_valid_n(conv_valid_n),
    .conv_clk(conv_clk),
    .sample_in(sample_in),
    .edge_no(edge_no),
    .cap_stb(cap_stb),
    .cap_ok(cap_ok),
    .cap_word(cap_word)
  );
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // ********************************
  // Checks and bus tasks.
  // ********************************
  task automatic wrap_up;
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic guard(input int k);
    if (k > LIM) begin
      num_errors++;
      $display("mismatch at %0t: wait timed out", $time);
      wrap_up();
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr_chk(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    int n;
    bh = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
      if (bh) s_axi_bready <= 1'h0;
      n++;
      guard(n);
    end
    chk_reg(32'(r), 32'(er));
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    rh = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'h0;
      if (rh) s_axi_rready <= 1'h0;
      n++;
      guard(n);
    end
    chk_reg(d, e);
    chk_reg(32'(r), 32'(er));
  endtask
  task automatic wait_valid(input int mn, input int mx);
    int e0, n, de;
    e0 = int'(edge_no);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      guard(n);
    end while (conv_valid_n !== 1'h0);
    de = int'(edge_no) - e0;
    chk_bit(de >= mn && de <= mx, 1'h1);
  endtask
  task automatic run_rows(input int cnt);
    logic [31:0] e_last;
    int n;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      do begin
        @(negedge aclk);
        n++;
        guard(n);
      end while (cap_stb !== 1'h1);
      chk_bit(cap_ok, 1'h1);
      chk_word(cap_word, ROWS[(edge_no - 32'd14) % NR].w);
      if (i > 0) chk_reg(edge_no, e_last + 32'h0000_0001);
      e_last = edge_no;
    end
  endtask
  // ********************************
  // Main sequence.
  // ********************************
  initial begin
    repeat (9) @(posedge aclk);
    @(negedge aclk);
    chk_word(data_o, 16'h0000);
    chk_bit(conv_valid_n, 1'h1);
    chk_bit(s_axi_bvalid | s_axi_rvalid, 1'h0);
    @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(`PAOC_OFF_CTRL, `PAOC_CTRL_RESET, `PAOC_RESP_OKAY);
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0004, `PAOC_RESP_OKAY);
    wait_valid(13, 30);
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0108, `PAOC_RESP_OKAY);
    run_rows(2 * NR);
    @(posedge aclk);
    read_n <= 1'h1;
    @(negedge aclk);
    chk_bit(data_oe, 1'h0);
    @(posedge aclk);
    read_n <= 1'h0;
    @(negedge aclk);
    chk_bit(data_oe, 1'h1);
    rd_chk(32'h0000_0010, 32'h0000_0000, `PAOC_RESP_DECERR);
    wr_chk(`PAOC_OFF_STATUS, 32'h0000_0000, `PAOC_RESP_DECERR);
    sleep_request_n <= 1'h0;
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0010, `PAOC_RESP_OKAY);
    hold = data_o;
    repeat (12) @(negedge aclk);
    chk_word(data_o, hold);
    chk_bit(conv_valid_n, 1'h1);
    @(posedge aclk);
    sleep_request_n <= 1'h1;
    wait_valid(13, 30);
    wr_chk(`PAOC_OFF_CTRL, 32'h0000_0001, `PAOC_RESP_OKAY);
    rd_chk(`PAOC_OFF_CTRL, 32'h0000_0001, `PAOC_RESP_OKAY);
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0010, `PAOC_RESP_OKAY);
    wr_chk(`PAOC_OFF_CTRL, 32'h0000_0000, `PAOC_RESP_OKAY);
    wait_valid(12, 30);
    @(posedge aclk);
    cal_start <= 1'h1;
    repeat (16) @(posedge aclk);
    cal_start <= 1'h0;
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0002, `PAOC_RESP_OKAY);
    wait_valid(CAL + 9, CAL + 60);
    wr_chk(`PAOC_OFF_CTRL, 32'h0000_0002, `PAOC_RESP_OKAY);
    rd_chk(`PAOC_OFF_CTRL, 32'h0000_0000, `PAOC_RESP_OKAY);
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0002, `PAOC_RESP_OKAY);
    wait_valid(CAL + 10, CAL + 60);
    @(posedge aclk);
    conv_reset <= 1'h1;
    rd_chk(`PAOC_OFF_STATUS, 32'h0000_0001, `PAOC_RESP_OKAY);
    @(negedge aclk);
    chk_bit(conv_valid_n, 1'h1);
    repeat (8) @(posedge aclk);
    conv_reset <= 1'h0;
    wait_valid(13, 30);
    run_rows(NR);
    wrap_up();
  end
endmodule
`default_nettype wire
